// file: sdcg_board_model.sv
// sdcg_board_model.sv: board side of the block: reset pin and address latch
// assumes: same crystal clock as the block; pin pulled down when undriven
`timescale 1ns/1ps
module sdcg_board_model (
  // crystal, reset, strobe
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        strobe_in,
  // reset pin parties
  input  wire logic        hold_high_in,
  input  wire logic        pin_drv_in,
  input  wire logic        pin_oe_in,
  // pin level and latch count
  output logic             pin_level_out,
  output logic [15:0]      latch_cnt_out
);
  logic stb_prev_r;
  // device drive wins, else the board button, else pull-down
  assign pin_level_out = pin_oe_in ? pin_drv_in : hold_high_in;
  always_ff @(posedge clk_sys_in) begin
    stb_prev_r <= strobe_in;
    if (reset_in)
      latch_cnt_out <= 16'h0000;
    else if (strobe_in && !stb_prev_r)
      latch_cnt_out <= latch_cnt_out + 16'h0001;
  end
endmodule : sdcg_board_model

// file: sdcg_clock_gen.sv
// sdcg_clock_gen.sv: core clock generation with speed doubling.
// assumes: clk_sys_in is the crystal_input, the core time base is given as
// one-cycle phase enables, and register writes come from the core.
//
// What this block does
// (R1) A reset pin held high for two machine cycles resets the device.
// (R2) On watchdog time-out the reset pin is driven out while the time-out lasts.
// (R3) The address strobe runs at 1/6 of oscillator, 1/3 in double speed.
// (R4) One strobe pulse is dropped on each external data memory access.
// (R5) With the strobe-disable bit set, internal fetches emit no strobe.
// (R6) The crystal is divided by two before the core unless bypassed.
// (R7) A machine cycle is 12 crystal periods, or 6 in double speed.
// (R8) Reset selects standard speed with the divider active.
// (R9) Mode changes take effect only on a rising divided-clock edge.
// (R10) Peripheral time bases run twice as fast in double speed.
// (R11) The double speed bit is bit 0 of the clock control register at 8Fh.
// (R12) Switching sources never yields a phase shorter than a crystal period.
`timescale 1ns/1ps
`include "sdcg_defs.svh"

module sdcg_clock_gen #(
  parameter int unsigned PHASES = `SDCG_PHASES_PER_CYCLE
) (
  // clock and reset
  input  wire logic               clk_sys_in,
  input  wire logic               reset_in,
  // special function register writes from the core
  input  wire logic               sfr_wr_in,
  input  wire logic [7:0]         sfr_addr_in,
  input  wire logic [7:0]         sfr_wdata_in,
  input  wire logic               aux_ctrl_wr_in,
  // core status
  input  wire logic               ext_data_access_in,
  input  wire logic               int_fetch_in,
  input  wire logic               wdog_timeout_in,
  // reset pin
  input  wire logic               reset_pin_in,
  output logic                    reset_pin_out,
  output logic                    reset_pin_oe_out,
  // core side
  output logic                    core_reset_out,
  output logic                    phase_tick_out,
  output logic                    mcycle_start_out,
  output logic                    periph_tick_out,
  output sdcg_pkg::sdcg_mode_t    speed_mode_out,
  output logic [7:0]              clock_config_reg_out,
  // address latch strobe
  output logic                    addr_strobe_out
);
  import sdcg_pkg::*;

  localparam int unsigned PW = $clog2(PHASES);
  localparam int unsigned RQ = PHASES * `SDCG_RST_QUAL_CYCLES;
  localparam int unsigned RW = $clog2(RQ + 1);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic            div_r;
  logic            div_nxt;
  logic            dbl_req_r;
  sdcg_mode_t      mode_r;
  sdcg_mode_t      mode_nxt;
  logic            stb_dis_r;
  logic [PW-1:0]   phase_r;
  logic [PW-1:0]   phase_nxt;
  logic            tick_r;
  logic            mstart_r;
  logic            stb_r;
  logic            stb_nxt;
  logic            skip_r;
  logic            skip_nxt;
  logic [2:0]      pin_sync_r;
  logic            pin_level_r;
  logic [RW-1:0]   qual_r;
  logic [RW-1:0]   qual_nxt;
  sdcg_rst_state_t rst_st_r;
  sdcg_rst_state_t rst_st_nxt;
  logic            core_rst_r;
  logic            oe_r;

  // ----------------------------------------------------------------------
  // divider and mode select
  // ----------------------------------------------------------------------
  wire cfg_hit  = sfr_wr_in && (sfr_addr_in == `SDCG_CLK_CFG_ADDR); // R11
  wire div_rise = !div_r;                  // divided clock rises next edge
  assign div_nxt  = !div_r;                                         // R6
  // mode follows the request only as the divided clock rises, so a
  // switch never cuts a phase shorter than one crystal period
  assign mode_nxt = div_rise ? (dbl_req_r ? SDCG_DOUBLE_SPEED_MODE
                                          : SDCG_STANDARD_SPEED_MODE)
                             : mode_r;                              // R9
  // one phase per crystal period, or per two in standard speed
  wire tick_en  = (mode_r == SDCG_DOUBLE_SPEED_MODE) || div_rise;   // R7 R12

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      div_r     <= 1'b0;
      dbl_req_r <= `SDCG_CLK_CFG_RESET;                             // R8
      mode_r    <= SDCG_STANDARD_SPEED_MODE;                        // R8
      stb_dis_r <= `SDCG_STB_DIS_RESET;
    end else begin
      div_r  <= div_nxt;
      mode_r <= mode_nxt;
      if (cfg_hit)
        dbl_req_r <= sfr_wdata_in[`SDCG_DBL_SEL_BIT];               // R11
      if (aux_ctrl_wr_in)
        stb_dis_r <= sfr_wdata_in[`SDCG_STB_DIS_BIT];               // R5
    end
  end

  // ----------------------------------------------------------------------
  // phase generator and strobe
  // ----------------------------------------------------------------------
  wire last_phase = (phase_r == PW'(PHASES - 1));
  assign phase_nxt = !tick_en ? phase_r :
                     last_phase ? '0 : phase_r + PW'(1);            // R7
  // strobe asserted on phases 0 and 3: two per machine cycle
  wire stb_phase  = tick_en && ((phase_nxt == '0) ||
                    (phase_nxt == PW'(PHASES / `SDCG_STB_PER_CYCLE)));
  // drop the first strobe after an external data access
  assign skip_nxt = ext_data_access_in ? 1'b1 :
                    (stb_phase ? 1'b0 : skip_r);                    // R4
  wire stb_fire   = stb_phase && !skip_r &&
                    !(stb_dis_r && int_fetch_in);                   // R3 R5
  // strobe stands one phase, then drops
  assign stb_nxt  = stb_fire ? 1'b1 : (tick_en ? 1'b0 : stb_r);

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      phase_r  <= '0;
      tick_r   <= 1'b0;
      mstart_r <= 1'b0;
      stb_r    <= 1'b0;
      skip_r   <= 1'b0;
    end else begin
      phase_r  <= phase_nxt;
      tick_r   <= tick_en;                                          // R10
      mstart_r <= tick_en && last_phase;
      stb_r    <= stb_nxt;
      skip_r   <= skip_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // reset pin qualification and watchdog drive
  // ----------------------------------------------------------------------
  // three flops; a new level counts once the last two agree
  // our own watchdog drive reads back here, so a long one is
  // held on by the external path until the pin has fallen
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pin_sync_r  <= 3'h0;
      pin_level_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], reset_pin_in};
      if (pin_sync_r[1] == pin_sync_r[2])
        pin_level_r <= pin_sync_r[2];
    end
  end

  // ----------------------------------------------------------------------
  // reset state
  // ----------------------------------------------------------------------
  // qualification counts phase ticks: two machine cycles
  wire qual_done = (qual_r == RW'(RQ));
  assign qual_nxt = !pin_level_r ? '0 :
                    (tick_en && !qual_done) ? qual_r + RW'(1) : qual_r; // R1

  always_comb begin
    rst_st_nxt = rst_st_r;
    unique case (rst_st_r)
      SDCG_RST_IDLE: begin
        if (wdog_timeout_in)
          rst_st_nxt = SDCG_RST_WDOG;                               // R2
        else if (qual_done)
          rst_st_nxt = SDCG_RST_EXT;                                // R1
      end
      SDCG_RST_EXT: begin
        if (wdog_timeout_in)
          rst_st_nxt = SDCG_RST_WDOG;                               // R2
        else if (!pin_level_r)
          rst_st_nxt = SDCG_RST_IDLE;
      end
      SDCG_RST_WDOG: begin
        if (!wdog_timeout_in)
          rst_st_nxt = SDCG_RST_IDLE;                               // R2
      end
      default: rst_st_nxt = SDCG_RST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      qual_r     <= '0;
      rst_st_r   <= SDCG_RST_IDLE;
      core_rst_r <= 1'b1;
      oe_r       <= 1'b0;
    end else begin
      qual_r     <= qual_nxt;
      rst_st_r   <= rst_st_nxt;
      // core reset and pin drive follow the next state
      core_rst_r <= (rst_st_nxt != SDCG_RST_IDLE);
      oe_r       <= (rst_st_nxt == SDCG_RST_WDOG);                  // R2
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // pin only ever driven high; released, it falls to its pull-down
  assign reset_pin_out        = oe_r;
  assign reset_pin_oe_out     = oe_r;
  assign core_reset_out       = core_rst_r;
  assign phase_tick_out       = tick_r;
  assign mcycle_start_out     = mstart_r;
  assign periph_tick_out      = tick_r;
  assign speed_mode_out       = mode_r;
  assign clock_config_reg_out = {7'h00, dbl_req_r};
  assign addr_strobe_out      = stb_r;

endmodule : sdcg_clock_gen

// file: sdcg_clock_gen_chk.sv
// sdcg_clock_gen_chk.sv: port checks on the clock generator
// assumes: bound to every sdcg_clock_gen instance
`timescale 1ns/1ps
module sdcg_clock_gen_chk
  import sdcg_pkg::*;
#(parameter int unsigned PHASES = 6) (
  input wire logic                 clk_sys_in,
  input wire logic                 reset_in,
  input wire logic                 sfr_wr_in,
  input wire logic [7:0]           sfr_addr_in,
  input wire logic [7:0]           sfr_wdata_in,
  input wire logic                 ext_data_access_in,
  input wire logic                 wdog_timeout_in,
  input wire logic                 reset_pin_oe_out,
  input wire logic                 core_reset_out,
  input wire logic                 phase_tick_out,
  input wire logic                 periph_tick_out,
  input wire sdcg_pkg::sdcg_mode_t speed_mode_out,
  input wire logic [7:0]           clock_config_reg_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  wire cfg_wr = sfr_wr_in && sfr_addr_in == 8'h8f;
  wire dbl = speed_mode_out == SDCG_DOUBLE_SPEED_MODE;
  cfg_write_a: assert property (
    cfg_wr |=> clock_config_reg_out == {7'h00, $past(sfr_wdata_in[0])})
    else $error("config readback wrong");
  cfg_hold_a: assert property (!cfg_wr |=> $stable(clock_config_reg_out))
    else $error("config changed without write");
  mode_follow_a: assert property (
    clock_config_reg_out[0] != dbl |-> ##[1:2] clock_config_reg_out[0] == dbl)
    else $error("speed mode late");
  dbl_tick_a: assert property (dbl [*3] |-> phase_tick_out)
    else $error("double speed phase missing");
  std_tick_a: assert property (
    !dbl [*4] |-> phase_tick_out != $past(phase_tick_out))
    else $error("standard phase not halved");
  periph_tick_a: assert property (periph_tick_out == phase_tick_out)
    else $error("peripheral time base off");
  wdog_drive_a: assert property (
    wdog_timeout_in |=> reset_pin_oe_out && core_reset_out)
    else $error("watchdog reset not driven");
  wdog_release_a: assert property (!wdog_timeout_in |=> !reset_pin_oe_out)
    else $error("reset pin still driven");
  dbl_seen_c: cover property (dbl [*8]);
  skip_seen_c: cover property (ext_data_access_in);
  wdog_seen_c: cover property (reset_pin_oe_out);
endmodule : sdcg_clock_gen_chk
bind sdcg_clock_gen sdcg_clock_gen_chk #(.PHASES(PHASES)) u_chk (
  .clk_sys_in           (clk_sys_in),
  .reset_in             (reset_in),
  .sfr_wr_in            (sfr_wr_in),
  .sfr_addr_in          (sfr_addr_in),
  .sfr_wdata_in         (sfr_wdata_in),
  .ext_data_access_in   (ext_data_access_in),
  .wdog_timeout_in      (wdog_timeout_in),
  .reset_pin_oe_out     (reset_pin_oe_out),
  .core_reset_out       (core_reset_out),
  .phase_tick_out       (phase_tick_out),
  .periph_tick_out      (periph_tick_out),
  .speed_mode_out       (speed_mode_out),
  .clock_config_reg_out (clock_config_reg_out)
);

// file: sdcg_defs.svh
// sdcg_defs.svh: offsets, field positions, reset values and counts for the
// speed doubling clock generator.
// assumes: included by bare name from the package and the design file.
`ifndef SDCG_DEFS_SVH
`define SDCG_DEFS_SVH

// ----------------------------------------------------------------------
// clock control register
// ----------------------------------------------------------------------
`define SDCG_CLK_CFG_ADDR      8'h8f
`define SDCG_DBL_SEL_BIT       0
`define SDCG_CLK_CFG_RESET     1'b0

// ----------------------------------------------------------------------
// auxiliary control register
// ----------------------------------------------------------------------
`define SDCG_STB_DIS_BIT       0
`define SDCG_STB_DIS_RESET     1'b0

// ----------------------------------------------------------------------
// machine cycle figures
// ----------------------------------------------------------------------
`define SDCG_PHASES_PER_CYCLE  6
`define SDCG_STD_PER_CYCLE     12
`define SDCG_DBL_PER_CYCLE     6
`define SDCG_STB_PER_CYCLE     2
`define SDCG_RST_QUAL_CYCLES   2

`endif

// file: sdcg_pkg.sv
// sdcg_pkg.sv: types of the speed doubling clock generator.
// assumes: sdcg_defs.svh is on the include path.
`include "sdcg_defs.svh"

package sdcg_pkg;

  // ----------------------------------------------------------------------
  // speed mode
  // ----------------------------------------------------------------------
  typedef enum logic {
    SDCG_STANDARD_SPEED_MODE,
    SDCG_DOUBLE_SPEED_MODE
  } sdcg_mode_t;

  // ----------------------------------------------------------------------
  // reset pin state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SDCG_RST_IDLE,
    SDCG_RST_EXT,
    SDCG_RST_WDOG
  } sdcg_rst_state_t;

endpackage : sdcg_pkg

// file: tb_top.sv
// tb_top.sv: scenario bench of the clock generator
// assumes: board model and checker compiled before
`timescale 1ns/1ps
module tb_top;
  import sdcg_pkg::*;
  logic clk, rst, wr, aux, ext, fetch, wdog, hold;
  logic [7:0] addr, wdata, cfg;
  logic pin, pin_o, oe, core_rst, tick, mc, ptick, stb;
  logic [15:0] latched;
  sdcg_mode_t mode;
  int mismatches, compares, t, m, s, p;
  sdcg_clock_gen dut (.clk_sys_in(clk), .reset_in(rst), .sfr_wr_in(wr),
    .sfr_addr_in(addr), .sfr_wdata_in(wdata), .aux_ctrl_wr_in(aux),
    .ext_data_access_in(ext), .int_fetch_in(fetch), .wdog_timeout_in(wdog),
    .reset_pin_in(pin), .reset_pin_out(pin_o), .reset_pin_oe_out(oe),
    .core_reset_out(core_rst), .phase_tick_out(tick), .mcycle_start_out(mc),
    .periph_tick_out(ptick), .speed_mode_out(mode),
    .clock_config_reg_out(cfg), .addr_strobe_out(stb));
  sdcg_board_model board (.clk_sys_in(clk), .reset_in(rst), .strobe_in(stb),
    .hold_high_in(hold), .pin_drv_in(pin_o), .pin_oe_in(oe),
    .pin_level_out(pin), .latch_cnt_out(latched));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : step
  task automatic chk(input logic ok);
    compares++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t mismatch", $time);
    end
  endtask : chk
  task automatic measure(input int n);
    logic [15:0] base;
    base = latched;
    t = 0;
    m = 0;
    p = 0;
    repeat (n) begin
      step(1);
      t += int'(tick === 1'b1);
      m += int'(mc === 1'b1);
      p += int'(ptick === 1'b1);
    end
    s = int'(latched - base);
    if ($isunknown(latched))
      s = -1;
  endtask : measure
  task automatic wr_cfg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(3);
  endtask : wr_cfg
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial begin
    #400000;
    mismatches++;
    final_report();
  end
  initial begin
    {rst, wr, aux, ext, fetch, wdog, hold} = 7'h40;
    addr = 8'h00;
    wdata = 8'h00;
    step(10);
    rst = 1'b0;
    step(4);
    chk(cfg === 8'h00 && mode === SDCG_STANDARD_SPEED_MODE);
    measure(120);
    chk(t == 60 && m == 10 && s == 20);
    wr_cfg(8'h8e, 8'h01);
    chk(cfg === 8'h00);
    wr_cfg(8'h8f, 8'h01);
    chk(cfg === 8'h01 && mode === SDCG_DOUBLE_SPEED_MODE);
    measure(60);
    chk(t == 60 && p == 60 && m == 10 && s == 20);
    ext = 1'b1;
    step(1);
    ext = 1'b0;
    measure(60);
    chk(s == 19);
    {aux, wdata, fetch} = 10'h203;
    step(1);
    aux = 1'b0;
    step(1);
    measure(60);
    chk(s == 0);
    fetch = 1'b0;
    step(1);
    measure(60);
    chk(s == 20);
    wr_cfg(8'h8f, 8'h00);
    measure(120);
    chk(mode === SDCG_STANDARD_SPEED_MODE && m == 10);
    wdog = 1'b1;
    step(1);
    chk(oe === 1'b1 && core_rst === 1'b1 && pin === 1'b1);
    wdog = 1'b0;
    step(2);
    chk(oe === 1'b0 && pin === 1'b0);
    hold = 1'b1;
    step(6);
    hold = 1'b0;
    step(10);
    chk(core_rst === 1'b0);
    hold = 1'b1;
    step(40);
    chk(core_rst === 1'b1);
    hold = 1'b0;
    step(6);
    chk(core_rst === 1'b0);
    wr_cfg(8'h8f, 8'h01);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(2);
    chk(cfg === 8'h00 && mode === SDCG_STANDARD_SPEED_MODE);
    chk(core_rst === 1'b0 && oe === 1'b0);
    final_report();
  end
endmodule : tb_top
